// >>> core/agrc_regs.sv
// Purpose: Gain/rate, offset, full-scale and revision registers behind AXI4-Lite,
//          with the calibration datapath attached.
// Assumes: Register index times four is the byte address; only strobe lane 0 matters.
// Notes:   Unmapped addresses read zero and answer SLVERR.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "agrc_map.svh"
module agrc_regs
  import agrc_pkg::*;
#(
  parameter logic [3:0]      REVISION = 4'h5, // Arbitrary value
  parameter logic [8*24-1:0] TRIM     = {8{24'h400000}}
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Conversion path
  input  wire logic        raw_valid,
  input  wire logic [23:0] raw_data,
  output logic             cal_valid,
  output logic [23:0]      cal_data,
  // Front end control
  output agrc_gain_t       amp_gain_code,
  output agrc_rate_t       output_rate_code,
  output logic             ready_signal_select
);
  logic [7:0]     gain_rate_ff;
  agrc_coef_t     offset_coeff_ff;
  agrc_coef_t     full_scale_coeff_ff;
  logic           ready_sel_ff;
  logic [2:0]     monitor_select_ff;
  logic           reload_ff;
  agrc_coef_t     trim_ff;
  logic [31:0]    awaddr_ff;
  logic [31:0]    wdata_ff;
  logic [3:0]     wstrb_ff;
  logic           aw_held_ff;
  logic           w_held_ff;
  logic           bvalid_ff;
  logic [1:0]     bresp_ff;
  agrc_rd_state_t rd_state_ff;
  logic [31:0]    rdata_ff;
  logic [1:0]     rresp_ff;
  logic           wr_fire;
  logic [3:0]     wr_idx;
  logic [7:0]     wr_byte;
  logic           wr_lane0;
  logic [7:0]     nxt_gain_rate;
  agrc_gain_t     trim_gain;

  agrc_cal_if cal ();

  // Word index from a byte address; upper bits must be zero to hit
  function automatic logic [4:0] idx_of(input logic [31:0] addr);
    if (addr[31:6] != 26'h0 || addr[1:0] != 2'h0) begin
      return 5'h10;
    end else begin
      return {1'b0, addr[5:2]};
    end
  endfunction

  // Mapped index test used by the write decode and the write response
  function automatic logic is_mapped(input logic [4:0] idx);
    return (idx >= {1'b0, `AGRC_IDX_GAIN_RATE}) && (idx <= {1'b0, `AGRC_IDX_MONITOR});
  endfunction

  // Write channels are taken independently and held until both are present
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign wr_fire  = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_idx   = awaddr_ff[5:2];
  assign wr_byte  = wdata_ff[7:0];
  assign wr_lane0 = wr_fire && wstrb_ff[0] && is_mapped(idx_of(awaddr_ff));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= 32'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      wdata_ff  <= 32'h0;
      wstrb_ff  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff  <= s_axi_wdata;
      wstrb_ff  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_ff <= 1'b0;
    end
  end

  // Write response, one clock after both channels are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `AGRC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= is_mapped(idx_of(awaddr_ff)) ? `AGRC_RESP_OKAY : `AGRC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // Top bit is reserved and never stored
  assign nxt_gain_rate = wr_byte & `AGRC_GAIN_RATE_WMASK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gain_rate_ff <= `AGRC_GAIN_RATE_RST;
    end else if (wr_lane0 && wr_idx == `AGRC_IDX_GAIN_RATE) begin
      gain_rate_ff <= nxt_gain_rate;
    end
  end

  // Reload request on reset and on any change of the stored gain code
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_ff <= 1'b1;
    end else begin
      reload_ff <= wr_lane0 && wr_idx == `AGRC_IDX_GAIN_RATE &&
                   nxt_gain_rate[6:4] != gain_rate_ff[6:4];
    end
  end

  // Look up the code the register holds after this clock, so the trim is
  // ready when the reload lands instead of lagging the gain change
  always_comb begin
    if (wr_lane0 && wr_idx == `AGRC_IDX_GAIN_RATE) begin
      trim_gain = nxt_gain_rate[6:4];
    end else begin
      trim_gain = gain_rate_ff[6:4];
    end
  end

  // Trim is looked up from the programmed code, not the forced one
  agrc_trim_rom #(
    .TRIM      (TRIM)
  ) u_trim (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .gain_code (trim_gain),
    .trim_ff   (trim_ff)
  );

  // Offset bytes, low byte at the lowest index
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      offset_coeff_ff <= 24'h000000;
    end else if (wr_lane0 && wr_idx == `AGRC_IDX_OFS_LOW) begin
      offset_coeff_ff[7:0] <= wr_byte;
    end else if (wr_lane0 && wr_idx == `AGRC_IDX_OFS_MID) begin
      offset_coeff_ff[15:8] <= wr_byte;
    end else if (wr_lane0 && wr_idx == `AGRC_IDX_OFS_HIGH) begin
      offset_coeff_ff[23:16] <= wr_byte;
    end
  end

  // Full-scale bytes; the trim reload lands the clock after the ROM settles.
  // A host write in that very clock loses to the reload.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      full_scale_coeff_ff <= `AGRC_FS_UNITY;
    end else if (reload_ff) begin
      full_scale_coeff_ff <= trim_ff;
    end else if (wr_lane0 && wr_idx == `AGRC_IDX_FS_LOW) begin
      full_scale_coeff_ff[7:0] <= wr_byte;
    end else if (wr_lane0 && wr_idx == `AGRC_IDX_FS_MID) begin
      full_scale_coeff_ff[15:8] <= wr_byte;
    end else if (wr_lane0 && wr_idx == `AGRC_IDX_FS_HIGH) begin
      full_scale_coeff_ff[23:16] <= wr_byte;
    end
  end

  // Only the ready select is writable; revision and low bits stay fixed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ready_sel_ff <= 1'b0;
    end else if (wr_lane0 && wr_idx == `AGRC_IDX_REV) begin
      ready_sel_ff <= wr_byte[`AGRC_RDY_SEL_BIT];
    end
  end

  // Monitor select copy, since the multiplexer register sits elsewhere
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      monitor_select_ff <= 3'h0;
    end else if (wr_lane0 && wr_idx == `AGRC_IDX_MONITOR) begin
      monitor_select_ff <= wr_byte[2:0];
    end
  end

  // Calibration monitors force unity gain; the stored code is kept
  always_comb begin
    if (monitor_select_ff == `AGRC_MON_GAIN_CAL || monitor_select_ff == `AGRC_MON_TEMP) begin
      amp_gain_code = 3'h0;
    end else begin
      amp_gain_code = gain_rate_ff[6:4];
    end
  end
  assign output_rate_code    = gain_rate_ff[3:0];
  assign ready_signal_select = ready_sel_ff;

  // Read machine: take address, present data, hold until accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_ff <= AGRC_RD_IDLE;
    end else begin
      case (rd_state_ff)
        AGRC_RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state_ff <= AGRC_RD_RESP;
          end
        end
        AGRC_RD_RESP: begin
          rd_state_ff <= s_axi_rready ? AGRC_RD_IDLE : AGRC_RD_HOLD;
        end
        AGRC_RD_HOLD: begin
          if (s_axi_rready) begin
            rd_state_ff <= AGRC_RD_IDLE;
          end
        end
        default: begin
          rd_state_ff <= AGRC_RD_IDLE;
        end
      endcase
    end
  end
  assign s_axi_arready = (rd_state_ff == AGRC_RD_IDLE);
  assign s_axi_rvalid  = (rd_state_ff == AGRC_RD_RESP) || (rd_state_ff == AGRC_RD_HOLD);

  // Read data captured with the address; reserved bits return zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_ff <= 32'h0;
      rresp_ff <= `AGRC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rresp_ff <= `AGRC_RESP_OKAY;
      if (idx_of(s_axi_araddr) == {1'b0, `AGRC_IDX_GAIN_RATE}) begin
        rdata_ff <= {24'h0, gain_rate_ff};
      end else if (idx_of(s_axi_araddr) == {1'b0, `AGRC_IDX_OFS_LOW}) begin
        rdata_ff <= {24'h0, offset_coeff_ff[7:0]};
      end else if (idx_of(s_axi_araddr) == {1'b0, `AGRC_IDX_OFS_MID}) begin
        rdata_ff <= {24'h0, offset_coeff_ff[15:8]};
      end else if (idx_of(s_axi_araddr) == {1'b0, `AGRC_IDX_OFS_HIGH}) begin
        rdata_ff <= {24'h0, offset_coeff_ff[23:16]};
      end else if (idx_of(s_axi_araddr) == {1'b0, `AGRC_IDX_FS_LOW}) begin
        rdata_ff <= {24'h0, full_scale_coeff_ff[7:0]};
      end else if (idx_of(s_axi_araddr) == {1'b0, `AGRC_IDX_FS_MID}) begin
        rdata_ff <= {24'h0, full_scale_coeff_ff[15:8]};
      end else if (idx_of(s_axi_araddr) == {1'b0, `AGRC_IDX_FS_HIGH}) begin
        rdata_ff <= {24'h0, full_scale_coeff_ff[23:16]};
      end else if (idx_of(s_axi_araddr) == {1'b0, `AGRC_IDX_REV}) begin
        rdata_ff <= {24'h0, REVISION, ready_sel_ff, 3'h0};
      end else if (idx_of(s_axi_araddr) == {1'b0, `AGRC_IDX_MONITOR}) begin
        rdata_ff <= {29'h0, monitor_select_ff};
      end else begin
        rdata_ff <= 32'h0;
        rresp_ff <= `AGRC_RESP_SLVERR;
      end
    end
  end
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Datapath hookup
  assign cal.raw_valid        = raw_valid;
  assign cal.raw_data         = raw_data;
  assign cal.offset_coeff     = offset_coeff_ff;
  assign cal.full_scale_coeff = full_scale_coeff_ff;
  assign cal_valid            = cal.cal_valid;
  assign cal_data             = cal.cal_data;

  agrc_cal_dp u_dp (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cal     (cal)
  );
endmodule

// >>> common/agrc_map.svh
// Purpose: Offsets, field positions, reset values and constants of the gain/rate and
//          calibration register group.
// Assumes: AXI4-Lite slave, 32-bit data, one register per aligned word.
// Notes:   Printed offsets are indexes; the byte address is four times the index.
`ifndef AGRC_MAP_SVH
`define AGRC_MAP_SVH
`define AGRC_IDX_GAIN_RATE      4'h3
`define AGRC_IDX_OFS_LOW        4'h4
`define AGRC_IDX_OFS_MID        4'h5
`define AGRC_IDX_OFS_HIGH       4'h6
`define AGRC_IDX_FS_LOW         4'h7
`define AGRC_IDX_FS_MID         4'h8
`define AGRC_IDX_FS_HIGH        4'h9
`define AGRC_IDX_REV            4'ha
`define AGRC_IDX_MONITOR        4'hb
`define AGRC_GAIN_RATE_RST      8'h00
`define AGRC_GAIN_RATE_WMASK    8'h7f
`define AGRC_REV_WMASK          8'h08
`define AGRC_GAIN_LSB           4
`define AGRC_RDY_SEL_BIT        3
`define AGRC_FS_UNITY           24'h400000
`define AGRC_FS_SHIFT           22
`define AGRC_MON_GAIN_CAL       3'h2
`define AGRC_MON_TEMP           3'h3
`define AGRC_RESP_OKAY          2'h0
`define AGRC_RESP_SLVERR        2'h2
`endif

// >>> common/agrc_pkg.sv
// Purpose: Types shared by the calibration register group.
// Assumes: Constants live in agrc_map.svh.
// Notes:   Rate enumeration is in samples per second order.
package agrc_pkg;
  typedef logic [2:0] agrc_gain_t;
  typedef logic [3:0] agrc_rate_t;
  typedef logic [23:0] agrc_coef_t;
  typedef enum logic [2:0] {
    AGRC_RD_IDLE = 3'h1,
    AGRC_RD_RESP = 3'h2,
    AGRC_RD_HOLD = 3'h4
  } agrc_rd_state_t;
endpackage

// >>> common/agrc_cal_if.sv
// Purpose: Carries a conversion through the calibration datapath.
// Assumes: One clock shared by both ends.
// Notes:   Coefficient fields come straight from the register file.
`timescale 1ns/1ns
interface agrc_cal_if;
  logic        raw_valid;
  logic [23:0] raw_data;
  logic [23:0] offset_coeff;
  logic [23:0] full_scale_coeff;
  logic        cal_valid;
  logic [23:0] cal_data;
  modport regs (output raw_valid, raw_data, offset_coeff, full_scale_coeff,
                input cal_valid, cal_data);
  modport dp   (input raw_valid, raw_data, offset_coeff, full_scale_coeff,
                output cal_valid, cal_data);
endinterface

// >>> core/agrc_trim_rom.sv
// Purpose: Factory full-scale trim for each gain code, registered read.
// Assumes: Trim values are parameters; defaults are plain unity.
// Notes:   Read data appear one clock after the code.
`timescale 1ns/1ns
module agrc_trim_rom
  import agrc_pkg::*;
#(
  parameter logic [8*24-1:0] TRIM = {8{24'h400000}}
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Lookup
  input  wire agrc_gain_t gain_code,
  output agrc_coef_t      trim_ff
);
  // Registered lookup keeps the reload path short
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Gain code is zero after reset, so the reset reload finds its trim here
      trim_ff <= TRIM[23:0];
    end else begin
      trim_ff <= TRIM[gain_code*24 +: 24];
    end
  end
endmodule

// >>> core/agrc_cal_dp.sv
// Purpose: Offset subtraction and full-scale scaling of each conversion.
// Assumes: Raw data and offset are two's complement 24-bit.
// Notes:   Result saturates to the 24-bit range; latency is one clock.
`timescale 1ns/1ns
`include "agrc_map.svh"
module agrc_cal_dp
  import agrc_pkg::*;
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Datapath
  agrc_cal_if.dp    cal
);
  logic signed [24:0] diff;
  logic signed [49:0] prod;
  logic signed [49:0] scaled;

  // Offset first, then scale by coefficient over unity
  always_comb begin
    diff   = $signed({cal.raw_data[23], cal.raw_data}) -
             $signed({cal.offset_coeff[23], cal.offset_coeff});
    prod   = 50'(diff) * $signed({1'b0, cal.full_scale_coeff});
    scaled = prod >>> `AGRC_FS_SHIFT;
  end

  // Saturate rather than wrap so a large gain trim cannot flip the sign
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal.cal_valid <= 1'b0;
      cal.cal_data  <= 24'h000000;
    end else begin
      cal.cal_valid <= cal.raw_valid;
      if (cal.raw_valid) begin
        if (scaled > 50'sh7fffff) begin
          cal.cal_data <= 24'h7fffff;
        end else if (scaled < -50'sh800000) begin
          cal.cal_data <= 24'h800000;
        end else begin
          cal.cal_data <= scaled[23:0];
        end
      end
    end
  end
endmodule

// >>> bench/agrc_regs_chk.sv
// Purpose: Port-level checks of the calibration register group.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Read data are judged against the last accepted read address.
`timescale 1ns/1ns
module agrc_regs_chk
  import agrc_pkg::*;
#(
  parameter logic [3:0] REVISION = 4'h5
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Datapath and control
  input wire logic        raw_valid,
  input wire logic        cal_valid,
  input wire agrc_gain_t  amp_gain_code,
  input wire agrc_rate_t  output_rate_code,
  input wire logic        ready_signal_select
);
  logic [31:0] ar_ff;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Address of the read now being answered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_ff <= 32'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      ar_ff <= s_axi_araddr;
    end
  end

  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  cal_lat_a: assert property (raw_valid |=> cal_valid) else $error("result late");
  cal_once_a: assert property (!raw_valid |=> !cal_valid) else $error("stray result");
  reset_val_a: assert property ($rose(aresetn) |-> amp_gain_code == 3'h0 &&
    output_rate_code == 4'h0 && !ready_signal_select) else $error("bad reset state");
  gain_rd_a: assert property (s_axi_rvalid && ar_ff == 32'h0c |->
    !s_axi_rdata[7] && s_axi_rdata[3:0] == output_rate_code) else $error("bad gain read");
  rev_rd_a: assert property (s_axi_rvalid && ar_ff == 32'h28 |->
    s_axi_rdata[7:0] == {REVISION, ready_signal_select, 3'h0}) else $error("bad rev read");
endmodule

// >>> bench/agrc_host.sv
// Purpose: Host model driving AXI4-Lite register cycles.
// Assumes: One write or one read at a time.
// Notes:   raw=1 skips the zero-fill of reserved bits on purpose.
`timescale 1ns/1ns
module agrc_host (
  // Clock
  input wire logic         aclk,
  // Requests
  output logic [31:0]      s_axi_awaddr,
  output logic             s_axi_awvalid,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  output logic             s_axi_bready,
  output logic [31:0]      s_axi_araddr,
  output logic             s_axi_arvalid,
  output logic             s_axi_rready,
  // Answers
  input wire logic         s_axi_awready,
  input wire logic         s_axi_wready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_arready,
  input wire logic [31:0]  s_axi_rdata,
  input wire logic [1:0]   s_axi_rresp,
  input wire logic         s_axi_rvalid
);
  // Idle bus at time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
  end

  task automatic wr(input logic [31:0] a, input logic [7:0] d, input bit raw,
                    output logic [1:0] r);
    int n;
    r = 2'bxx;
    if (!raw && a == 32'h0c) d[7] = 1'b0;
    if (!raw && a == 32'h28) d[2:0] = 3'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;  // Released lines must not look valid
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~s_axi_wdata;
      end
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 64) tb_top.hang();
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 64) tb_top.hang();
  endtask
endmodule

// >>> bench/tb_top.sv
// Purpose: Self-checking bench of the calibration register group.
// Assumes: Seeded random data plus fixed corner cases.
// Notes:   Trim values differ per gain so a wrong reload shows.
`timescale 1ns/1ns
module tb_top;
  import agrc_pkg::*;
  logic aclk, aresetn, raw_valid, cal_valid, ready_signal_select;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [23:0] raw_data, cal_data, o, f, v;
  agrc_gain_t amp_gain_code;
  agrc_rate_t output_rate_code;
  logic [7:0] mon [4] = '{8'h02, 8'h03, 8'h01, 8'h00};
  int failures, n_tests, i, j;

  function automatic agrc_coef_t tr(int k);
    return 24'h3f8000 + 24'(k) * 24'h001357;
  endfunction
  function automatic logic [191:0] mk_trim();
    for (int k = 0; k < 8; k++) mk_trim[k*24 +: 24] = tr(k);
  endfunction
  // Offset first, then scale, floor, saturate
  function automatic logic [23:0] exp_cal(logic [23:0] x, logic [23:0] ofs, logic [23:0] fs);
    logic signed [49:0] p;
    p = ($signed({x[23], x}) - $signed({ofs[23], ofs})) * $signed({1'b0, fs});
    p = p >>> 22;
    if (p > 50'sd8388607) return 24'h7fffff;
    if (p < -50'sd8388608) return 24'h800000;
    return p[23:0];
  endfunction

  agrc_regs #(.REVISION(4'h9), .TRIM(mk_trim())) uut (.*); // Revision value is arbitrary
  agrc_host host (.*);

  always #5 aclk = ~aclk;

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wchk(logic [31:0] a, logic [7:0] x, logic [1:0] e);
    host.wr(a, x, 1'b0, r);
    chk("bresp", r, e);
  endtask
  task automatic rchk(logic [31:0] a, logic [31:0] e);
    host.rd(a, d, r);
    chk("rdata", d, e);
    chk("rresp", r, 2'h0);
  endtask
  task automatic rd24(logic [31:0] a, output logic [23:0] x);
    for (int k = 0; k < 3; k++) begin
      host.rd(a + 4 * k, d, r);
      x[8*k +: 8] = d[7:0];
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic hang();
    failures++;
    print_verdict();
  endtask

  initial begin
    {aclk, aresetn, raw_valid, raw_data} = '0;
    i = $urandom(12264);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(32'h0c, 32'h0);
    for (j = 0; j < 3; j++) rchk(32'h10 + 4 * j, 32'h0);
    rd24(32'h1c, v);
    chk("fsc reset", v, tr(0));
    rchk(32'h28, 32'h90);
    $display("test reset values done");
    // Every rate code, and a gain change on each step after the first
    for (i = 0; i < 16; i++) begin
      wchk(32'h0c, {1'b0, i[2:0], i[3:0]}, 2'h0);
      @(negedge aclk);
      chk("gain", amp_gain_code, i[2:0]);
      chk("rate", output_rate_code, i[3:0]);
      repeat (2) @(posedge aclk);
      rd24(32'h1c, v);
      chk("fsc reload", v, tr(i % 8));
    end
    foreach (mon[k]) begin
      wchk(32'h2c, mon[k], 2'h0);
      @(negedge aclk);
      chk("forced gain", amp_gain_code, mon[k][1] ? 3'h0 : 3'h7);
    end
    $display("test gain and rate done");
    host.wr(32'h0c, 8'hff, 1'b1, r);
    rchk(32'h0c, 32'h7f);
    host.wr(32'h28, 8'hff, 1'b1, r);
    rchk(32'h28, 32'h98);
    chk("ready sel", ready_signal_select, 1'b1);
    wchk(32'h30, 8'h5a, 2'h2);
    host.rd(32'h00, d, r);
    chk("unmapped rdata", d, 32'h0);
    chk("unmapped rresp", r, 2'h2);
    $display("test reserved bits done");
    // Coefficients and calibrated results
    for (i = 0; i < 8; i++) begin
      o = 24'($urandom);
      f = 24'($urandom);
      if (i == 0) {o, f} = {24'h0, 24'h400000};
      if (i == 1) {o, f} = {24'h800000, 24'hffffff};
      for (j = 0; j < 3; j++) begin
        wchk(32'h10 + 4 * j, o[8*j +: 8], 2'h0);
        wchk(32'h1c + 4 * j, f[8*j +: 8], 2'h0);
      end
      rd24(32'h10, v);
      chk("offset", v, o);
      rd24(32'h1c, v);
      chk("full scale", v, f);
      @(posedge aclk);
      raw_data <= 24'($urandom);
      raw_valid <= 1'b1;
      @(posedge aclk);
      raw_valid <= 1'b0;
      @(negedge aclk);
      chk("cal valid", cal_valid, 1'b1);
      chk("cal data", cal_data, exp_cal(raw_data, o, f));
    end
    $display("test calibration done");
    print_verdict();
  end
endmodule

bind agrc_regs agrc_regs_chk #(.REVISION(4'h9)) chk_i (.*);
